// ==== core/qdw_pkg.sv ====
// Shared constants for the quad converter two-wire write receiver and the
// matching bus master. Assumes a single 50 MHz system clock on both ends.
`default_nettype none

package qdw_pkg;

  // System clock and the bus clock that the master generates
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 10000;
  // One bus clock period is split into four quarter steps
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // Fixed upper five bits of the 7-bit slave address
  localparam logic [4:0] ADDR_PREFIX = 5'h13;

  // Control byte field positions
  localparam int CTL_EXT_HI = 7;
  localparam int CTL_EXT_LO = 6;
  localparam int CTL_LOAD_HI = 5;
  localparam int CTL_LOAD_LO = 4;
  localparam int CTL_CH_HI = 2;
  localparam int CTL_CH_LO = 1;
  localparam int CTL_PD_SEL = 0;

  // Load field codes
  localparam logic [1:0] LOAD_STAGE_ONLY = 2'h0;
  localparam logic [1:0] LOAD_ONE = 2'h1;
  localparam logic [1:0] LOAD_ALL = 2'h2;

  // First power-down byte: mode bits at the top
  localparam int PD_MODE_HI = 7;
  localparam int PD_MODE_LO = 6;

  // Channel register layout
  localparam int NUM_CH = 4;
  localparam int REG_W = 14;
  localparam int DATA_W = 12;
  localparam logic [13:0] REG_RESET = 14'h0000;

  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

endpackage

`default_nettype wire

// ==== core/qdw_if.sv ====
// Two-wire bus between the master end and the receiver end.
// Open-drain lines with pull-ups; the interface resolves wire levels.
`default_nettype none

interface qdw_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Pulled high unless a party enables its low driver
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

  modport master (
    output scl_o,
    output scl_oe,
    output sda_m_o,
    output sda_m_oe,
    input scl,
    input sda
  );

  modport device (
    output sda_d_o,
    output sda_d_oe,
    input scl,
    input sda
  );
endinterface

`default_nettype wire

// ==== core/qdw_receiver.sv ====
// Write receiver end of the quad 12-bit converter serial port.
// Assumes bus pins arrive asynchronously and are sampled by ref_clk,
// which must run well above the bus clock rate.
//
// Function
// [R1] Transfer: START, address with write bit, control
// [R2] First byte after address is control byte
// [R3] Control bits 2 and 1 select channel
// [R4] Control bit 0 picks data or power-down
// [R5] Data mode accepts high/low pairs until end
// [R6] Master sends bits 11..4 MSB first
// [R7] Low byte upper nibble data, rest ignored
// [R8] Power-down mode takes exactly two bytes
// [R9] Acknowledge address, control and each byte
// [R10] Pairs repeat without re-addressing until end
// [R11] Master should end with repeated START
// [R12] Apply pair at falling edge ending ack
// [R13] Per channel 14-bit staging and output registers
// [R14] Load bits zero: staging only, no update
// [R15] Control acted on only if extended bits match
// [R16] Ignore traffic until START and own address
`default_nettype none

module qdw_receiver
  import qdw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  qdw_if.device bus,
  input wire logic slave_address_pin_bit_1,
  input wire logic slave_address_pin_bit_0,
  input wire logic extended_address_bit_high,
  input wire logic extended_address_bit_low,
  output logic [NUM_CH-1:0][REG_W-1:0] channel_staging_register,
  output logic [NUM_CH-1:0][REG_W-1:0] channel_output_register,
  output logic output_update
);

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_CTRL,
    ST_HI,
    ST_LO,
    ST_PDH,
    ST_PDL,
    ST_SKIP
  } qdw_rx_state_t;

  qdw_rx_state_t state;
  qdw_rx_state_t next_state;

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic in_ack;
  logic ack_oe;
  logic apply_pend;
  logic [7:0] ctrl;
  logic [7:0] hi_byte;

  // Bus lines pass two flops; the third stage only serves edge finding
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end
    else
    begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
    end
  end

  // Address strap pins are static but still synchronised
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end
    else
    begin
      pin_s1 <= {extended_address_bit_high, extended_address_bit_low,
                 slave_address_pin_bit_1, slave_address_pin_bit_0};
      pin_s2 <= pin_s1;
    end
  end

  // Bus events from the synchronised samples
  wire scl_now = scl_s[1];
  wire sda_now = sda_s[1];
  wire scl_rise = scl_now & ~scl_s[2];
  wire scl_fall = ~scl_now & scl_s[2];
  wire start_det = scl_now & scl_s[2] & sda_s[2] & ~sda_now;
  wire stop_det = scl_now & scl_s[2] & ~sda_s[2] & sda_now;
  wire byte_full = (bit_cnt == BYTE_BITS);
  wire receiving = (state != ST_IDLE) && (state != ST_SKIP);

  // [R1] [R16] own address, write bit clear
  wire addr_match = (shreg[7:3] == ADDR_PREFIX) &&
                    (shreg[2:1] == pin_s2[1:0]) && !shreg[0];
  // [R15] extended address check
  wire ext_match = (shreg[CTL_EXT_HI:CTL_EXT_LO] == pin_s2[3:2]);

  // Decide acknowledge for the byte just completed
  // [R9] ack every accepted byte
  wire want_ack = (state == ST_ADDR) ? addr_match :
                  (state == ST_CTRL) ? ext_match :
                  (state == ST_HI) || (state == ST_LO) ||
                  (state == ST_PDH) || (state == ST_PDL);

  // Control fields, taken from the stored control byte
  // [R3] channel select
  wire [1:0] sel_ch = ctrl[CTL_CH_HI:CTL_CH_LO];
  // [R4] power-down select
  wire pd_sel = ctrl[CTL_PD_SEL];
  wire [1:0] load_mode = ctrl[CTL_LOAD_HI:CTL_LOAD_LO];

  // Successor state after an acknowledged byte
  always_comb
  begin
    next_state = ST_SKIP;
    unique case (state)
      ST_ADDR: next_state = ST_CTRL;
      // [R2] [R4] control byte picks the data path
      ST_CTRL: next_state = shreg[CTL_PD_SEL] ? ST_PDH : ST_HI;
      ST_HI: next_state = ST_LO;
      // [R5] [R10] pairs loop until STOP or START
      ST_LO: next_state = ST_HI;
      ST_PDH: next_state = ST_PDL;
      // [R8] only two power-down bytes
      ST_PDL: next_state = ST_SKIP;
      ST_IDLE: next_state = ST_SKIP;
      ST_SKIP: next_state = ST_SKIP;
    endcase
  end

  // New channel word built from the pair just received
  // [R6] [R7] data bits 11..0; low nibble dropped
  // [R8] power-down keeps the stored data bits
  wire [REG_W-1:0] data_word = {2'h0, hi_byte, shreg[7:4]};
  wire [REG_W-1:0] pd_word = {hi_byte[PD_MODE_HI:PD_MODE_LO],
                              channel_staging_register[sel_ch][DATA_W-1:0]};
  wire [REG_W-1:0] new_word = pd_sel ? pd_word : data_word;

  // Byte engine: shift on rise, ack on fall, release on next fall
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      ack_oe <= 1'b0;
      apply_pend <= 1'b0;
      ctrl <= 8'h00;
      hi_byte <= 8'h00;
    end
    else if (start_det)
    begin
      // [R1] [R10] a (repeated) START returns to addressing
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      ack_oe <= 1'b0;
      apply_pend <= 1'b0;
    end
    else if (stop_det)
    begin
      // [R16] STOP releases the line and idles
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      ack_oe <= 1'b0;
      apply_pend <= 1'b0;
    end
    else if (receiving && scl_rise && !in_ack && !byte_full)
    begin
      // [R6] most significant bit arrives first
      shreg <= {shreg[6:0], sda_now};
      bit_cnt <= bit_cnt + 4'h1;
    end
    else if (receiving && scl_fall && byte_full && !in_ack)
    begin
      if (want_ack)
      begin
        // [R9] pull data low for the ack bit
        ack_oe <= 1'b1;
        in_ack <= 1'b1;
        state <= next_state;
        if (state == ST_CTRL)
          ctrl <= shreg;
        if (state == ST_HI || state == ST_PDH)
          hi_byte <= shreg;
        apply_pend <= (state == ST_LO) || (state == ST_PDL);
      end
      else
        state <= ST_SKIP; // Not for us: stay off the bus until next START
    end
    else if (in_ack && scl_fall)
    begin
      // End of ack bit: release, and let the apply stage fire
      ack_oe <= 1'b0;
      in_ack <= 1'b0;
      bit_cnt <= 4'h0;
      apply_pend <= 1'b0;
    end
  end

  // Apply strobe: falling edge that closes the ack after the low byte
  // [R12] update timing
  wire apply_now = in_ack && scl_fall && apply_pend && !start_det &&
                   !stop_det;

  // Channel registers; low byte still sits in shreg at this point
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_staging_register <= {NUM_CH{REG_RESET}};
      channel_output_register <= {NUM_CH{REG_RESET}};
      output_update <= 1'b0;
    end
    else
    begin
      output_update <= 1'b0;
      if (apply_now)
      begin
        // [R13] staging always takes the new word
        // [R14] load code zero stops here
        channel_staging_register[sel_ch] <= new_word;
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (load_mode == LOAD_ALL)
            channel_output_register[i] <= (i == int'(sel_ch)) ?
              new_word : channel_staging_register[i];
          else if (load_mode == LOAD_ONE && i == int'(sel_ch))
            channel_output_register[i] <= new_word;
        end
        output_update <= (load_mode == LOAD_ONE) ||
                         (load_mode == LOAD_ALL);
      end
    end
  end

  // Open-drain: only ever drives low
  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = ack_oe;

endmodule

`default_nettype wire

// ==== core/qdw_master.sv ====
// Bus master end: sends one write per command (address, control and
// one byte pair) and ends with STOP or keeps the bus for a repeated START.
// Assumes the receiver acks within a quarter bus period; no stretching.
// [R11] a command may close with repeated START by clearing cmd_stop
`default_nettype none

module qdw_master
  import qdw_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  qdw_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_addr,
  input wire logic [7:0] cmd_ctrl,
  input wire logic [7:0] cmd_hi,
  input wire logic [7:0] cmd_lo,
  input wire logic cmd_stop,
  output logic done,
  output logic nack
);

  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_HOLD} qdw_m_state_t;

  qdw_m_state_t state;
  logic [15:0] qcnt;
  logic [1:0] phase;
  logic [2:0] bitn;
  logic [1:0] byte_idx;
  logic [7:0] sh;
  logic [7:0] ctrl_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [1:0] addr_q;
  logic stop_q;
  logic scl_oe;
  logic sda_oe;
  logic [1:0] sda_s;

  // Quarter-period enable from the divider
  wire tick = (qcnt == 16'(QUARTER - 1));
  wire take = cmd_valid && cmd_ready;

  // [R1] address with write bit, then control, high, low
  // [R6] [R7] [R8] bytes go out as given, MSB first
  wire [7:0] next_byte = (byte_idx == 2'h0) ? ctrl_q :
                         (byte_idx == 2'h1) ? hi_q : lo_q;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      sda_s <= 2'h3;
    else
      sda_s <= {sda_s[0], bus.sda};
  end

  // Divider runs all the time, also when idle; a taken command restarts it
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      qcnt <= 16'h0000;
    else if (take || tick)
      qcnt <= 16'h0000;
    else
      qcnt <= qcnt + 16'h0001;
  end

  // Sequencer: each tick advances one quarter of a bus bit
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= M_IDLE;
      phase <= 2'h0;
      bitn <= 3'h0;
      byte_idx <= 2'h0;
      sh <= 8'h00;
      {ctrl_q, hi_q, lo_q} <= 24'h000000;
      addr_q <= 2'h0;
      stop_q <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      nack <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (take)
      begin
        {ctrl_q, hi_q, lo_q} <= {cmd_ctrl, cmd_hi, cmd_lo};
        addr_q <= cmd_addr;
        stop_q <= cmd_stop;
        cmd_ready <= 1'b0;
        nack <= 1'b0;
        phase <= 2'h0;
        state <= M_START;
      end
      else if (tick && state != M_IDLE && state != M_HOLD)
      begin
        phase <= phase + 2'h1;
        unique case (state)
          M_START:
            unique case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              2'h3:
              begin
                scl_oe <= 1'b1;
                sh <= {ADDR_PREFIX, addr_q, 1'b0};
                bitn <= 3'h7;
                byte_idx <= 2'h0;
                state <= M_BIT;
              end
            endcase
          M_BIT:
            unique case (phase)
              2'h0: sda_oe <= ~sh[7];
              2'h1: scl_oe <= 1'b0;
              2'h2: scl_oe <= 1'b0;
              2'h3:
              begin
                scl_oe <= 1'b1;
                sh <= {sh[6:0], 1'b0};
                bitn <= bitn - 3'h1;
                if (bitn == 3'h0)
                  state <= M_ACK;
              end
            endcase
          M_ACK:
            unique case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: nack <= sda_s[1];
              2'h3:
              begin
                scl_oe <= 1'b1;
                if (nack || byte_idx == 2'h3)
                begin
                  state <= (nack || stop_q) ? M_STOP : M_HOLD;
                  done <= !(nack || stop_q);
                  cmd_ready <= !(nack || stop_q);
                end
                else
                begin
                  sh <= next_byte;
                  byte_idx <= byte_idx + 2'h1;
                  bitn <= 3'h7;
                  state <= M_BIT;
                end
              end
            endcase
          M_STOP:
            unique case (phase)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              2'h3:
              begin
                state <= M_IDLE;
                done <= 1'b1;
                cmd_ready <= 1'b1;
              end
            endcase
          default: state <= M_IDLE;
        endcase
      end
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_oe;

endmodule

`default_nettype wire

// ==== verif/qdw_monitor.sv ====
// Checker for the two-wire bus joining master and receiver.
// Assumes both ends run on ref_clk and the master uses QUARTER of 8.
`default_nettype none

module qdw_monitor
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_scl;
  logic prev_sda;
  logic prev_ack;
  logic in_frame;
  logic [3:0] bit_cnt;
  logic start_seen;
  logic stop_seen;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Bus conditions: SDA moves while SCL stays high
  assign start_seen = prev_scl && scl && prev_sda && !sda;
  assign stop_seen = prev_scl && scl && !prev_sda && sda;

  // Previous levels; lines idle high, so reset to 1
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      {prev_scl, prev_sda, prev_ack} <= 3'h6;
    else
      {prev_scl, prev_sda, prev_ack} <= {scl, sda, sda_d_oe};
  end

  // Frame flag and clock rises since START or the last ack
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      {in_frame, bit_cnt} <= 5'h00;
    else if (start_seen)
      {in_frame, bit_cnt} <= 5'h10;
    else if (stop_seen)
      in_frame <= 1'b0;
    else if (prev_ack && !sda_d_oe)
      bit_cnt <= 4'h0;
    else if (!prev_scl && scl)
      bit_cnt <= bit_cnt + 4'h1;
  end

  property p_ack_edge_low;
    $changed(sda_d_oe) |-> !scl;
  endproperty
  a_ack_edge_low: assert property (p_ack_edge_low)
    else $error("ack changed while clock high");
  property p_ack_count;
    $rose(sda_d_oe) |-> bit_cnt == 4'h8;
  endproperty
  a_ack_count: assert property (p_ack_count)
    else $error("ack not after eight clock rises");
  property p_ack_len;
    $rose(sda_d_oe) |-> ##[24:40] $fell(sda_d_oe);
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("ack length wrong");
  property p_ack_rise;
    $rose(sda_d_oe) |-> ##[1:40] ($rose(scl) && !sda);
  endproperty
  a_ack_rise: assert property (p_ack_rise)
    else $error("ack not sampled by a clock rise");
  property p_ack_lag;
    $rose(sda_d_oe) |-> !$past(scl, 1) && !$past(scl, 2);
  endproperty
  a_ack_lag: assert property (p_ack_lag)
    else $error("ack raised too soon after clock fall");
  property p_stop_release;
    stop_seen |-> !sda_d_oe [*4];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("receiver drives data at stop");
  property p_idle;
    !in_frame && !start_seen |-> !sda_m_oe && !sda_d_oe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("data driven outside a frame");
  property p_scl_high;
    $rose(scl) |-> scl [*6];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  property p_open_drain;
    (sda_d_oe |-> !sda_d_o && !sda) and (sda_m_oe |-> !sda_m_o && !sda)
      and (scl_oe |-> !scl_o && !scl);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("bus line driven high or not low while enabled");

  // Main scenarios reached
  c_ack: cover property ($rose(sda_d_oe));
  c_stop: cover property (stop_seen);
  c_restart: cover property (start_seen && in_frame);
endmodule

`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench: master and receiver joined by one bus.
// Assumes the package constants and a master with QUARTER of 8.
`default_nettype none

module testbench
  import qdw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] STRAP = 2'h2;
  localparam logic [1:0] EXT = 2'h1;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  logic [7:0] cmd_ctrl = 8'h00;
  logic [7:0] cmd_hi = 8'h00;
  logic [7:0] cmd_lo = 8'h00;
  logic cmd_stop = 1'b1;
  logic cmd_ready;
  logic done;
  logic nack;
  logic output_update;
  logic [NUM_CH-1:0][REG_W-1:0] stage;
  logic [NUM_CH-1:0][REG_W-1:0] outreg;
  logic [13:0] exp_st [4] = '{default: 14'h0000};
  logic [13:0] exp_out [4] = '{default: 14'h0000};
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int upd_count = 0;

  qdw_if bus();
  qdw_master #(.QUARTER(8)) qdw_master_i (.ref_clk(ref_clk),
    .resetn(resetn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_ctrl(cmd_ctrl),
    .cmd_hi(cmd_hi), .cmd_lo(cmd_lo), .cmd_stop(cmd_stop), .done(done),
    .nack(nack));
  qdw_receiver qdw_receiver_i (.ref_clk(ref_clk), .resetn(resetn),
    .bus(bus), .slave_address_pin_bit_1(STRAP[1]),
    .slave_address_pin_bit_0(STRAP[0]),
    .extended_address_bit_high(EXT[1]), .extended_address_bit_low(EXT[0]),
    .channel_staging_register(stage), .channel_output_register(outreg),
    .output_update(output_update));
  qdw_monitor qdw_monitor_i (.ref_clk(ref_clk), .resetn(resetn),
    .scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .sda_m_o(bus.sda_m_o),
    .sda_m_oe(bus.sda_m_oe), .sda_d_o(bus.sda_d_o),
    .sda_d_oe(bus.sda_d_oe), .scl(bus.scl), .sda(bus.sda));

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Update pulses counted mid-cycle, where the flop output has settled;
  // cycle ceiling cuts a hang short
  always @(negedge ref_clk)
  begin
    cycles++;
    if (output_update === 1'b1)
      upd_count++;
    if (cycles == 30000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [13:0] exp,
    input logic [13:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] ctl(input logic [1:0] ld,
    input logic [1:0] ch, input logic pd);
    return {EXT, ld, 1'b0, ch, pd};
  endfunction

  // One command through the master, then all channels and flags judged
  task automatic send(input logic [1:0] a, input logic [7:0] c,
    input logic [7:0] h, input logic [7:0] l, input logic st,
    input logic [13:0] upd, input logic nk);
    int n;
    int u;
    n = 0;
    u = upd_count;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge ref_clk);
      #2;
    end
    {cmd_addr, cmd_ctrl, cmd_hi, cmd_lo, cmd_stop} = {a, c, h, l, st};
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #2;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    chk("done", 14'h1, {13'h0, done});
    // A held bus ends on the ack fall, which the receiver sees late
    repeat (6) @(posedge ref_clk);
    #2;
    chk("nack", {13'h0, nk}, {13'h0, nack});
    chk("update", upd, 14'(upd_count - u));
    for (int i = 0; i < NUM_CH; i++)
    begin
      chk("stage", exp_st[i], stage[i]);
      chk("output", exp_out[i], outreg[i]);
    end
  endtask

  task automatic t_load_one;
    logic [7:0] hi;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      hi = 8'ha5 ^ 8'(ch);
      exp_st[ch] = {2'b00, hi, 4'h3};
      exp_out[ch] = exp_st[ch];
      send(STRAP, ctl(LOAD_ONE, 2'(ch), 1'b0), hi, 8'h3c, 1'b1, 14'h1,
        1'b0);
    end
  endtask

  // Staging only, ended by repeated START, then load all
  task automatic t_stage_then_all;
    exp_st[1] = 14'h05af;
    send(STRAP, ctl(LOAD_STAGE_ONLY, 2'h1, 1'b0), 8'h5a, 8'hf0, 1'b0,
      14'h0, 1'b0);
    exp_st[0] = 14'h0c39;
    exp_out = exp_st;
    send(STRAP, ctl(LOAD_ALL, 2'h0, 1'b0), 8'hc3, 8'h96, 1'b1, 14'h1,
      1'b0);
  endtask

  // Power-down bytes keep data and set the mode bits
  task automatic t_power_down;
    exp_st[3] = {2'b10, exp_st[3][11:0]};
    exp_out[3] = exp_st[3];
    send(STRAP, ctl(LOAD_ONE, 2'h3, 1'b1), 8'h80, 8'h0f, 1'b1, 14'h1,
      1'b0);
    exp_st[2] = {2'b11, exp_st[2][11:0]};
    send(STRAP, ctl(LOAD_STAGE_ONLY, 2'h2, 1'b1), 8'hc0, 8'h05, 1'b1,
      14'h0, 1'b0);
  endtask

  // Foreign extended bits or address: refused, nothing changes
  task automatic t_refuse;
    send(STRAP, {~EXT, LOAD_ONE, 1'b0, 2'h0, 1'b0}, 8'h11, 8'h20, 1'b1,
      14'h0, 1'b1);
    send(~STRAP, ctl(LOAD_ALL, 2'h1, 1'b0), 8'h22, 8'h30, 1'b1, 14'h0,
      1'b1);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    for (int i = 0; i < NUM_CH; i++)
      chk("reset", REG_RESET, stage[i] | outreg[i]);
    t_load_one();
    t_stage_then_all();
    t_power_down();
    t_refuse();
    test_done();
  end
endmodule

`default_nettype wire
